// File: logic/dabsr_pkg.sv
// package for the input-select and readback part of the serial command decoder
// assumes a 24-bit frame, mode bits first, shifted in msb first
package dabsr_pkg;
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] FRAME_LAST = 5'h18; // bit count of a complete frame
  localparam logic [1:0] MODE_SPECIAL = 2'h0;
  localparam logic [5:0] CODE_NOP = 6'h00;
  localparam logic [5:0] CODE_READ_SELECT = 6'h05;
  localparam logic [5:0] CODE_WRITE_SEL_LOW = 6'h06;
  localparam logic [5:0] CODE_WRITE_SEL_HIGH = 6'h07;
  localparam int RB_ADDR_LSB = 7; // lowest payload bit that names a register
  localparam logic [8:0] RB_ADDR_SEL_LOW = 9'h106;
  localparam logic [8:0] RB_ADDR_SEL_HIGH = 9'h107;
  localparam logic [8:0] RB_ADDR_RESET = 9'h000;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] RB_PAD = 8'h00; // upper bits of a returned word

  // one received command word
  typedef struct packed {
    logic [1:0] mode;
    logic [5:0] code; // code[5] is function_code_msb
    logic [15:0] function_payload;
  } dabsr_frame_t;

  // pins after synchronisation
  typedef struct packed {
    logic sclk;
    logic sync_n;
    logic sdi;
  } dabsr_pins_t;
endpackage : dabsr_pkg

// File: logic/dabsr_core.sv
// serial decoder part: input-register select registers and two-frame readback
// assumes sclk, sync_n and sdi come from the host asynchronously to clk_sys
// and that sclk runs well below a quarter of the clk_sys rate
`timescale 1ns/1ps

// Contract
// - readback register chosen from upper payload bits; lowest seven ignored
// - first select register bits seven..zero steer channels seven..zero
// - second select register bits seven..zero steer channels fifteen..eight
// - readback request only sets up; data appears during the following frame
// - mode bits zero mean special function: six code bits, sixteen payload bits
// - codes six and seven load low payload byte into select registers
// - code five latches payload as readback address for the next frame
module dabsr_core (
  input wire logic clk_sys, // system clock, 50 MHz
  input wire logic resetn, // asynchronous reset, active low
  input wire logic sclk, // serial clock pin
  input wire logic sync_n, // frame select pin, active low
  input wire logic sdi, // serial data in pin
  input wire logic [15:0] ext_read_data, // data of registers held elsewhere
  output logic sdo, // serial data out
  output logic [15:0] channel_input_select, // 1 selects the second input register
  output logic [8:0] readback_addr, // latched readback register address
  output logic readback_armed // a readback word waits for the next frame
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  dabsr_pkg::dabsr_pins_t pins_meta_reg, pins_sync_reg, pins_old_reg;
  dabsr_pkg::dabsr_pins_t pins_meta_next, pins_sync_next, pins_old_next;

  always_comb begin
    pins_meta_next = '{sclk: sclk, sync_n: sync_n, sdi: sdi};
    pins_sync_next = pins_meta_reg;
    pins_old_next = pins_sync_reg;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pins_meta_reg <= '{sclk: 1'b1, sync_n: 1'b1, sdi: 1'b0};
      pins_sync_reg <= '{sclk: 1'b1, sync_n: 1'b1, sdi: 1'b0};
      pins_old_reg <= '{sclk: 1'b1, sync_n: 1'b1, sdi: 1'b0};
    end else begin
      pins_meta_reg <= pins_meta_next;
      pins_sync_reg <= pins_sync_next;
      pins_old_reg <= pins_old_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge events on the synchronised pins
  logic frame_start, frame_end, sclk_fall;
  assign frame_start = pins_old_reg.sync_n && !pins_sync_reg.sync_n;
  assign frame_end = !pins_old_reg.sync_n && pins_sync_reg.sync_n;
  assign sclk_fall = pins_old_reg.sclk && !pins_sync_reg.sclk && !pins_sync_reg.sync_n;

  // returned word for a latched address; unknown addresses go to the rest of the decoder
  function automatic logic [15:0] rb_value(input logic [8:0] addr, input logic [15:0] sel,
                                           input logic [15:0] ext);
    case (addr)
      dabsr_pkg::RB_ADDR_SEL_LOW: rb_value = {8'h00, sel[7:0]};
      dabsr_pkg::RB_ADDR_SEL_HIGH: rb_value = {8'h00, sel[15:8]};
      default: rb_value = ext;
    endcase
  endfunction : rb_value

  ////////////////////////////////////////////////////////////////////////////
  // command decode helper

  // true when a complete frame carries the given special-function code
  function automatic logic cmd_hit(input dabsr_pkg::dabsr_frame_t w, input logic [4:0] cnt,
                                   input logic [5:0] code);
    // a frame short of 24 falls or in another mode is dropped without effect
    cmd_hit = (cnt == dabsr_pkg::FRAME_LAST) && (w.mode == dabsr_pkg::MODE_SPECIAL) &&
              (w.code == code);
  endfunction : cmd_hit

  ////////////////////////////////////////////////////////////////////////////
  // stored state of all groups
  logic [23:0] rx_reg, rx_next; // received bits, newest in bit 0
  logic [23:0] tx_reg, tx_next; // outgoing bits, next one in bit 23
  logic [4:0] count_reg, count_next; // sclk falls seen in this frame
  logic sdo_reg, sdo_next;
  logic [7:0] input_select_low_channels_reg, input_select_low_channels_next;
  logic [7:0] input_select_high_channels_reg, input_select_high_channels_next;
  logic [8:0] rb_addr_reg, rb_addr_next;
  logic armed_reg, armed_next;
  logic [23:0] load_word;
  dabsr_pkg::dabsr_frame_t word;
  logic wr_low_hit, wr_high_hit, rd_sel_hit;

  ////////////////////////////////////////////////////////////////////////////
  // serial shift group

  // next values: sample on each synchronised sclk fall, reload at frame start
  always_comb begin
    rx_next = rx_reg;
    tx_next = tx_reg;
    count_next = count_reg;
    sdo_next = sdo_reg;
    load_word = {dabsr_pkg::RB_PAD,
                 rb_value(rb_addr_reg,
                          {input_select_high_channels_reg, input_select_low_channels_reg},
                          ext_read_data)};
    if (frame_start) begin
      count_next = 5'h00;
      if (armed_reg) begin
        // the pending word leaves in this frame, never in the request frame
        sdo_next = load_word[23];
        tx_next = {load_word[22:0], 1'b0};
      end else begin
        // nothing pending: the line stays low for the whole frame
        sdo_next = 1'b0;
        tx_next = '0;
      end
    end else if (sclk_fall) begin
      // sdi is sampled and the next outgoing bit presented on the same fall
      rx_next = {rx_reg[22:0], pins_sync_reg.sdi};
      // count saturates, so an overlong frame keeps its last 24 bits
      if (count_reg != dabsr_pkg::FRAME_LAST) begin
        count_next = count_reg + 5'h01;
      end
      sdo_next = tx_reg[23];
      tx_next = {tx_reg[22:0], 1'b0};
    end else if (frame_end) begin
      // line back to low once the frame is over
      sdo_next = 1'b0;
    end
  end

  // registers of the shift group
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_reg <= '0;
      tx_reg <= '0;
      count_reg <= 5'h00;
      sdo_reg <= 1'b0;
    end else begin
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      count_reg <= count_next;
      sdo_reg <= sdo_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode, valid in the cycle of the synchronised frame end
  assign word = dabsr_pkg::dabsr_frame_t'(rx_reg);
  assign wr_low_hit = frame_end &&
                      cmd_hit(word, count_reg, dabsr_pkg::CODE_WRITE_SEL_LOW);
  assign wr_high_hit = frame_end &&
                       cmd_hit(word, count_reg, dabsr_pkg::CODE_WRITE_SEL_HIGH);
  assign rd_sel_hit = frame_end &&
                      cmd_hit(word, count_reg, dabsr_pkg::CODE_READ_SELECT);

  ////////////////////////////////////////////////////////////////////////////
  // input-register select group

  // next values: only the low payload byte is stored, the upper byte is ignored
  always_comb begin
    input_select_low_channels_next = input_select_low_channels_reg;
    input_select_high_channels_next = input_select_high_channels_reg;
    if (wr_low_hit) begin
      input_select_low_channels_next = word.function_payload[7:0];
    end
    if (wr_high_hit) begin
      input_select_high_channels_next = word.function_payload[7:0];
    end
  end

  // registers of the select group
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      input_select_low_channels_reg <= dabsr_pkg::SEL_RESET;
      input_select_high_channels_reg <= dabsr_pkg::SEL_RESET;
    end else begin
      input_select_low_channels_reg <= input_select_low_channels_next;
      input_select_high_channels_reg <= input_select_high_channels_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // readback group

  // next values: a request arms, the start of any later frame disarms
  always_comb begin
    rb_addr_next = rb_addr_reg;
    armed_next = armed_reg;
    if (frame_start) begin
      // the word was loaded into the shift group in this same cycle
      armed_next = 1'b0;
    end else if (rd_sel_hit) begin
      // lowest seven payload bits never reach the address; a later request overrides
      rb_addr_next = word.function_payload[15:dabsr_pkg::RB_ADDR_LSB];
      armed_next = 1'b1;
    end
  end

  // registers of the readback group
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rb_addr_reg <= dabsr_pkg::RB_ADDR_RESET;
      armed_reg <= 1'b0;
    end else begin
      rb_addr_reg <= rb_addr_next;
      armed_reg <= armed_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign sdo = sdo_reg;
  assign readback_addr = rb_addr_reg;
  assign readback_armed = armed_reg;

  // one select bit per output channel: bit n steers channel n
  for (genvar ch = 0; ch < $bits(input_select_low_channels_reg); ch++) begin : g_chan
    assign channel_input_select[ch] = input_select_low_channels_reg[ch];
    assign channel_input_select[ch + $bits(input_select_low_channels_reg)] =
      input_select_high_channels_reg[ch];
  end

endmodule : dabsr_core

// File: test/dabsr_core_sva.sv
// checker for the select registers and the readback handshake of the decoder
// assumes only the ports of dabsr_core, sampled on clk_sys
`timescale 1ns/1ps
module dabsr_core_sva (
  input wire logic clk_sys, // system clock
  input wire logic resetn, // reset, active low
  input wire logic sync_n, // frame select pin
  input wire logic sdo, // serial data out
  input wire logic [15:0] channel_input_select, // both select registers
  input wire logic [8:0] readback_addr, // latched readback address
  input wire logic readback_armed // readback word pending
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // output line quiet between frames, state changing only at frame starts and ends
  a_sdo_idle: assert property (sync_n [*6] |-> !sdo) else $error("sdo busy between frames");
  // state moves a fixed three cycles after the sync_n pin edge that caused it
  a_arm_rise: assert property ($rose(readback_armed) |-> $past(sync_n, 3) &&
    !$past(sync_n, 4)) else $error("armed away from frame end");
  a_arm_drop: assert property ($fell(readback_armed) |-> !$past(sync_n, 3) &&
    $past(sync_n, 4)) else $error("armed drop away from frame start");
  a_addr_latch: assert property ($changed(readback_addr) |-> readback_armed &&
    $past(sync_n, 3) && !$past(sync_n, 4)) else $error("address moved without request");
  a_sel_apart: assert property ($changed(channel_input_select) |-> $past(sync_n, 3) &&
    !$past(sync_n, 4) && $stable(readback_addr)) else $error("select moved badly");
  a_sel_low_only: assert property ($changed(channel_input_select[7:0])
    |-> $stable(channel_input_select[15:8])) else $error("low write hit high");
  a_sel_high_only: assert property ($changed(channel_input_select[15:8])
    |-> $stable(channel_input_select[7:0])) else $error("high write hit low");
endmodule : dabsr_core_sva
bind dabsr_core dabsr_core_sva dabsr_core_sva_i (.clk_sys(clk_sys), .resetn(resetn),
  .sync_n(sync_n), .sdo(sdo), .channel_input_select(channel_input_select),
  .readback_addr(readback_addr), .readback_armed(readback_armed));

// File: test/dabsr_host_model.sv
// host serial port model: one frame per call, msb first, sdo sampled before each fall
// assumes clk_sys at 50 MHz; sclk halves last five or six clk_sys cycles
`timescale 1ns/1ps
module dabsr_host_model (
  input wire logic clk_sys, // system clock
  output logic sclk, // serial clock, idle high
  output logic sync_n, // frame select
  output logic sdi, // serial data to device
  input wire logic sdo // serial data from device
);
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : wt
  // any 24-bit command frame; returned word collected bit by bit
  task automatic xfer(input logic [23:0] w, output logic [23:0] r);
    sync_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi = w[i];
      wt(6);
      r[i] = sdo;
      sclk = 1'b0;
      wt(5);
      sclk = 1'b1;
    end
    sync_n = 1'b1;
    sdi = ~sdi; // released line does not keep its value
    wt(6);
  endtask : xfer
endmodule : dabsr_host_model

// File: test/tb_top.sv
// self-checking bench: select writes, refused words and two-frame readbacks
// assumes the host model drives the serial pins of dabsr_core
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_top;
  logic clk_sys = 1'b0, resetn = 1'b0, sclk, sync_n, sdi, sdo, readback_armed;
  logic [15:0] ext_read_data = 16'h1234, channel_input_select;
  logic [8:0] readback_addr;
  logic [23:0] r;
  int fails = 0, num_checks = 0, cyc = 0;
  dabsr_host_model dabsr_host_model_i (.clk_sys(clk_sys), .sclk(sclk), .sync_n(sync_n),
    .sdi(sdi), .sdo(sdo));
  dabsr_core dabsr_core_i (.clk_sys(clk_sys), .resetn(resetn), .sclk(sclk), .sync_n(sync_n),
    .sdi(sdi), .ext_read_data(ext_read_data), .sdo(sdo),
    .channel_input_select(channel_input_select), .readback_addr(readback_addr),
    .readback_armed(readback_armed));
  // clock and hang guard
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  // readback requests: payload, expected address, expected returned word
  logic [15:0] pl[3] = '{16'h837f, 16'h8380, 16'h8580}; // GPIO read keeps low seven zero
  logic [8:0] ad[3] = '{9'h106, 9'h107, 9'h10b};
  logic [23:0] rw[3] = '{24'h0000ab, 24'h00005c, 24'h001234};
  initial begin
    repeat (5) @(posedge clk_sys);
    #2 resetn = 1'b1;
    `CHK("select", 16'h0000, channel_input_select)
    `CHK("armed", 1'b0, readback_armed)
    // first frame only once the pin synchronisers have settled
    repeat (3) @(posedge clk_sys);
    #2;
    dabsr_host_model_i.xfer(24'h06ffab, r);
    `CHK("sel low", 16'h00ab, channel_input_select)
    dabsr_host_model_i.xfer(24'h073c5c, r);
    `CHK("sel high", 16'h5cab, channel_input_select)
    dabsr_host_model_i.xfer(24'h460012, r);
    dabsr_host_model_i.xfer(24'h2600ff, r);
    `CHK("refused", 16'h5cab, channel_input_select)
    for (int k = 0; k < 3; k++) begin
      dabsr_host_model_i.xfer({8'h05, pl[k]}, r);
      `CHK("req frame", 24'h000000, r)
      `CHK("addr", ad[k], readback_addr)
      `CHK("armed", 1'b1, readback_armed)
      dabsr_host_model_i.xfer(24'h000000, r);
      `CHK("data", rw[k], r)
      `CHK("disarmed", 1'b0, readback_armed)
    end
    // a second request returns the first word and replaces the pending address
    dabsr_host_model_i.xfer(24'h058300, r);
    dabsr_host_model_i.xfer(24'h058380, r);
    `CHK("chained", 24'h0000ab, r)
    dabsr_host_model_i.xfer(24'h000000, r);
    `CHK("override", 24'h00005c, r)
    test_done();
  end
endmodule : tb_top
